// *** include/afoa_pkg.sv ***
package afoa_pkg;
  // Data path widths
  localparam int FILE_W = 8;
  localparam int ADDR_W = 12;
  localparam int PROG_W = 20;
  // Bit positions inside the condition flag register
  localparam int FLAG_C = 0;
  localparam int FLAG_NIB = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_WRAP = 3;
  localparam int FLAG_N = 4;
  localparam int FLAG_W = 5;
  // Reset values
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [11:0] PTR_RESET = 12'h000;
  // Special register addresses in the data space
  localparam logic [11:0] ADDR_FLAGS = 12'hfd8;
  localparam logic [11:0] ADDR_BANK = 12'hfd9;
  // Pointer page: fe0..fff, pair in addr[4:3], kind in addr[2:0]
  localparam logic [6:0] IND_PAGE = 7'h7f;
  localparam int PAIR_COUNT = 3;
  localparam logic [1:0] PAIR_NONE = 2'h3;
  localparam logic [2:0] KIND_PLAIN = 3'h0;
  localparam logic [2:0] KIND_POST_INC = 3'h1;
  localparam logic [2:0] KIND_POST_DEC = 3'h2;
  localparam logic [2:0] KIND_PRE_INC = 3'h3;
  localparam logic [2:0] KIND_ACC_OFFSET = 3'h4;
  localparam logic [2:0] KIND_LOW = 3'h5;
  localparam logic [2:0] KIND_HIGH = 3'h6;
  // Forced-access bank split and indexed window limit
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  // Operations handed over by the instruction decoder
  typedef enum logic [3:0] {
    OP_NOP              = 4'h0,
    OP_ADD_ACC_FILE     = 4'h1,
    OP_ADD_LITERAL      = 4'h2,
    OP_FILE_MINUS_ACC   = 4'h3,
    OP_LITERAL_MINUS_ACC = 4'h4,
    OP_AND_FILE         = 4'h5,
    OP_CLEAR_FILE       = 4'h6,
    OP_BIT_CLEAR        = 4'h7,
    OP_BIT_SET          = 4'h8,
    OP_NIBBLE_SWAP      = 4'h9,
    OP_FILE_TO_FILE     = 4'ha,
    OP_ACC_TO_FILE      = 4'hb,
    OP_ROTATE_RIGHT     = 4'hc,
    OP_ROTATE_LEFT      = 4'hd,
    OP_MOVE_LITERAL     = 4'he,
    OP_GOTO_LITERAL     = 4'hf
  } afoa_op_t;
endpackage : afoa_pkg

// *** hw/afoa_ptr_pair.sv ***
`timescale 1ns/1ps
`default_nettype none
module afoa_ptr_pair
  import afoa_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_step_inc,
  input  wire logic        i_step_dec,
  input  wire logic        i_wr_low,
  input  wire logic        i_wr_high,
  input  wire logic [7:0]  i_wdata,
  output logic      [11:0] o_ptr
);
  logic [11:0] next_ptr;

  // A byte write beats any step, so a write through a stepping operand
  // stores the value unmodified; steps carry across the byte boundary
  always_comb begin
    next_ptr = o_ptr;
    if (i_wr_low) begin
      next_ptr = {o_ptr[11:8], i_wdata};
    end else if (i_wr_high) begin
      next_ptr = {i_wdata[3:0], o_ptr[7:0]};
    end else if (i_step_inc) begin
      next_ptr = o_ptr + 12'h001;
    end else if (i_step_dec) begin
      next_ptr = o_ptr - 12'h001;
    end
  end

  // Pointer storage
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ptr <= PTR_RESET;
    end else begin
      o_ptr <= next_ptr;
    end
  end
endmodule : afoa_ptr_pair
`default_nettype wire

// *** hw/afoa_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
module afoa_alu
  import afoa_pkg::*;
(
  input  wire afoa_op_t   i_op,
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_w,
  input  wire logic       i_carry,
  input  wire logic [2:0] i_bit_sel,
  output logic      [7:0] o_result,
  output logic      [4:0] o_flags,
  output logic      [4:0] o_mask
);
  // Subtraction adds the complement plus one
  wire       is_sub  = (i_op == OP_FILE_MINUS_ACC) || (i_op == OP_LITERAL_MINUS_ACC);
  wire [7:0] addend  = is_sub ? ~i_w : i_w;
  wire [8:0] sum     = {1'b0, i_a} + {1'b0, addend} + {8'h00, is_sub};
  wire [4:0] low_sum = {1'b0, i_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};
  wire       ovf     = (i_a[7] == addend[7]) && (sum[7] != i_a[7]);
  wire [7:0] bit_one = 8'h01 << i_bit_sel;
  logic      cy;
  logic      nib;

  // Result and the set of flags each operation touches
  always_comb begin
    o_result = i_a;
    cy       = sum[8];
    nib      = low_sum[4];
    o_mask   = 5'h00;
    case (i_op)
      OP_ADD_ACC_FILE, OP_ADD_LITERAL,
      OP_FILE_MINUS_ACC, OP_LITERAL_MINUS_ACC: begin
        o_result = sum[7:0];
        o_mask   = 5'h1f;
      end
      OP_AND_FILE: begin
        o_result = i_a & i_w;
        o_mask   = 5'h14;
      end
      OP_CLEAR_FILE: begin
        o_result = 8'h00;
        o_mask   = 5'h04;
      end
      OP_BIT_CLEAR:    o_result = i_a & ~bit_one;
      OP_BIT_SET:      o_result = i_a | bit_one;
      OP_NIBBLE_SWAP:  o_result = {i_a[3:0], i_a[7:4]};
      OP_ACC_TO_FILE:  o_result = i_w;
      OP_ROTATE_RIGHT: begin
        o_result = {i_carry, i_a[7:1]};
        cy       = i_a[0];
        nib      = i_a[4];
        o_mask   = 5'h17;
      end
      OP_ROTATE_LEFT: begin
        o_result = {i_a[6:0], i_carry};
        cy       = i_a[7];
        nib      = i_a[3];
        o_mask   = 5'h17;
      end
      default:         o_result = i_a;
    endcase
  end

  // Negative follows the MSB, zero follows the whole result
  assign o_flags = {o_result[7], ovf, (o_result == 8'h00), nib, cy};
endmodule : afoa_alu
`default_nettype wire

// *** hw/afoa_core.sv ***
// What this block does
// - Flag-affecting result aimed at flag register is dropped; only flag effects apply.
// - Clearing the flag register sets zero and leaves other flags alone.
// - Bit clear/set, swap and all three moves never touch any flag.
// - Flags: negative 4, overflow 3, zero 2, nibble carry 1, carry 0; 7-5 zero.
// - Negative flag copies the result's top bit.
// - Overflow flag marks a signed result whose sign bit came out wrong.
// - Zero flag is set exactly when the result is zero.
// - Add/subtract: nibble carry is the carry out of bit 3.
// - Add/subtract: carry is the carry out of bit 7.
// - Subtract adds the complement, so carries read as inverted borrows.
// - Rotates load nibble carry from source bit 4 or bit 3.
// - Rotates load carry from the bit shifted out.
// - Access bit one joins bank selector and 8-bit address into 12 bits.
// - Access bit zero maps the address into the access bank, ignoring banks.
// - Full 12-bit addresses in the instruction bypass the bank selector.
// - Destination bit one writes the file, zero writes the accumulator.
// - Three pointer pairs, each a 12-bit address in two bytes.
// - Indirect operands reach the memory location their pointer pair names.
// - Indirect targets use the full pointer, ignoring bank and access bit.
// - Each pair offers increment, decrement and offset operand variants.
// - Indexed literal mode exists only with the extended set enabled.
// - Literal control transfers carry a 20-bit program address.
// - Post-inc/dec use then step; pre-inc steps first; offset adds signed accumulator.
// - Steps span the whole pair and leave the flags alone.
// - Access addresses 60h-7Fh stay in bank 0, 80h-FFh go to bank 15.
// - Extended set, access bit zero, address up to 5Fh: add third pointer.
`timescale 1ns/1ps
`default_nettype none
module afoa_core
  import afoa_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_exec,
  input  wire afoa_op_t    i_op,
  input  wire logic [7:0]  i_file_addr,
  input  wire logic        i_access_bit,
  input  wire logic        i_dest_bit,
  input  wire logic [2:0]  i_bit_sel,
  input  wire logic [7:0]  i_literal,
  input  wire logic [11:0] i_long_src,
  input  wire logic [11:0] i_long_dst,
  input  wire logic [19:0] i_prog_addr,
  input  wire logic        i_extended_isa_enable,
  input  wire logic [7:0]  i_rd_data,
  output logic             o_rd_en,
  output logic      [11:0] o_rd_addr,
  output logic             o_wr_en,
  output logic      [11:0] o_wr_addr,
  output logic      [7:0]  o_wr_data,
  output logic      [7:0]  o_acc,
  output logic      [7:0]  o_flags,
  output logic             o_prog_load,
  output logic      [19:0] o_prog_target
);
  logic [4:0]  flags;
  logic [4:0]  next_flags;
  logic [3:0]  bank_selector;
  logic [11:0] ptr [4];
  logic [7:0]  file_rd;
  logic [7:0]  alu_result;
  logic [4:0]  alu_flags;
  logic [4:0]  alu_mask;

  // Address classifier for the pointer page
  function automatic logic is_virtual(input logic [11:0] a);
    return (a[11:5] == IND_PAGE) && (a[4:3] != PAIR_NONE) && (a[2:0] <= KIND_ACC_OFFSET);
  endfunction : is_virtual

  // Effective address of a virtual operand; plain, post-inc and post-dec
  // use the pointer as it stands, and only the post kinds step it afterwards
  function automatic logic [11:0] resolve(input logic [2:0] kind,
                                          input logic [11:0] p,
                                          input logic [7:0] w);
    logic [11:0] r;
    r = p;
    case (kind)
      KIND_PRE_INC:    r = p + 12'h001;
      KIND_ACC_OFFSET: r = p + {{4{w[7]}}, w};
      default:     r = p;
    endcase
    return r;
  endfunction : resolve

  // Operation classes
  wire op_long   = (i_op == OP_FILE_TO_FILE);
  wire op_goto   = (i_op == OP_GOTO_LITERAL);
  wire lit_op    = (i_op == OP_ADD_LITERAL) || (i_op == OP_LITERAL_MINUS_ACC) ||
                   (i_op == OP_MOVE_LITERAL);
  wire uses_file = !lit_op && !op_goto && (i_op != OP_NOP);
  wire has_dest  = (i_op == OP_ADD_ACC_FILE) || (i_op == OP_FILE_MINUS_ACC) ||
                   (i_op == OP_AND_FILE) || (i_op == OP_NIBBLE_SWAP) ||
                   (i_op == OP_ROTATE_RIGHT) || (i_op == OP_ROTATE_LEFT);
  wire reads_file = uses_file && (i_op != OP_CLEAR_FILE) && (i_op != OP_ACC_TO_FILE);
  wire to_file   = (has_dest && i_dest_bit) || (uses_file && !has_dest);
  wire to_acc    = lit_op || (has_dest && !i_dest_bit);

  // Direct and forced-access address forming
  wire         idx_mode = i_extended_isa_enable && !i_access_bit &&
                          (i_file_addr <= INDEXED_LIMIT);
  wire [11:0]  idx_addr = ptr[2] + {4'h0, i_file_addr};
  wire [3:0]   acc_bank = (i_file_addr >= ACCESS_SPLIT) ?
                          ACCESS_HIGH_BANK : ACCESS_LOW_BANK;
  wire [11:0]  bank_addr = {bank_selector, i_file_addr};
  wire [11:0]  forced_addr = idx_mode ? idx_addr : {acc_bank, i_file_addr};
  wire [11:0]  direct_addr = i_access_bit ? bank_addr : forced_addr;

  // Long-form moves carry whole addresses, so the bank selector is unused
  wire [11:0] raw_src = op_long ? i_long_src : direct_addr;
  wire [11:0] raw_dst = op_long ? i_long_dst : direct_addr;

  // Virtual operand decode for source and destination
  wire        src_ind  = is_virtual(raw_src);
  wire        dst_ind  = is_virtual(raw_dst);
  wire [1:0]  src_pair = raw_src[4:3];
  wire [1:0]  dst_pair = raw_dst[4:3];
  wire [2:0]  src_kind = raw_src[2:0];
  wire [2:0]  dst_kind = raw_dst[2:0];

  // Indirect targets come from the full pointer, never from bank or access bit
  wire [11:0] eff_src = src_ind ? resolve(src_kind, ptr[src_pair], o_acc) : raw_src;
  wire [11:0] eff_dst = dst_ind ? resolve(dst_kind, ptr[dst_pair], o_acc) : raw_dst;

  // A pointer aimed at another virtual operand reads zero and drops writes
  wire src_null = src_ind && is_virtual(eff_src);
  wire dst_null = dst_ind && is_virtual(eff_dst);

  // Registers held inside this block
  wire src_flags = (eff_src == ADDR_FLAGS);
  wire src_bank  = (eff_src == ADDR_BANK);
  wire src_ptrb  = (eff_src[11:5] == IND_PAGE) && (eff_src[4:3] != PAIR_NONE) &&
                   ((eff_src[2:0] == KIND_LOW) || (eff_src[2:0] == KIND_HIGH));
  wire dst_flags = (eff_dst == ADDR_FLAGS);
  wire dst_bank  = (eff_dst == ADDR_BANK);
  wire dst_ptrb  = (eff_dst[11:5] == IND_PAGE) && (eff_dst[4:3] != PAIR_NONE) &&
                   ((eff_dst[2:0] == KIND_LOW) || (eff_dst[2:0] == KIND_HIGH));
  wire src_inner = src_flags || src_bank || src_ptrb;
  wire dst_inner = dst_flags || dst_bank || dst_ptrb;
  wire [11:0] src_ptr = ptr[eff_src[4:3]];

  // Operand fetch: inner registers are served here, the rest by the RAM
  always_comb begin
    file_rd = i_rd_data;
    if (src_null) begin
      file_rd = 8'h00;
    end else if (src_flags) begin
      file_rd = {3'b000, flags};
    end else if (src_bank) begin
      file_rd = {4'h0, bank_selector};
    end else if (src_ptrb && (eff_src[2:0] == KIND_LOW)) begin
      file_rd = src_ptr[7:0];
    end else if (src_ptrb) begin
      file_rd = {4'h0, src_ptr[11:8]};
    end
  end

  assign o_rd_en   = i_exec && reads_file && !src_inner && !src_null;
  assign o_rd_addr = eff_src;

  // Arithmetic and flag computation
  afoa_alu u_alu (
    .i_op      (i_op),
    .i_a       (lit_op ? i_literal : file_rd),
    .i_w       (o_acc),
    .i_carry   (flags[FLAG_C]),
    .i_bit_sel (i_bit_sel),
    .o_result  (alu_result),
    .o_flags   (alu_flags),
    .o_mask    (alu_mask)
  );

  wire file_wr    = i_exec && to_file && !dst_null;
  wire flag_dest  = file_wr && dst_flags;
  wire keep_result = !(flag_dest && (alu_mask != 5'h00));

  // Flag update: a flag-affecting op aimed at the flag register only
  // applies its flag effects; other ops store the result there
  always_comb begin
    next_flags = flags;
    if (i_exec) begin
      if (flag_dest && (alu_mask == 5'h00)) begin
        next_flags = alu_result[FLAG_W-1:0];
      end else begin
        next_flags = (flags & ~alu_mask) | (alu_flags & alu_mask);
      end
    end
  end

  // Pointer pairs with their byte writes and automatic steps
  genvar n;
  generate
    for (n = 0; n < PAIR_COUNT; n++) begin : g_pair
      wire src_hit = i_exec && uses_file && src_ind && (src_pair == 2'(n));
      wire dst_hit = i_exec && op_long && dst_ind && (dst_pair == 2'(n));
      wire inc_src = src_hit && ((src_kind == KIND_POST_INC) || (src_kind == KIND_PRE_INC));
      wire dec_src = src_hit && (src_kind == KIND_POST_DEC);
      wire inc_dst = dst_hit && ((dst_kind == KIND_POST_INC) || (dst_kind == KIND_PRE_INC));
      wire dec_dst = dst_hit && (dst_kind == KIND_POST_DEC);
      wire wr_byte = file_wr && dst_ptrb && (eff_dst[4:3] == 2'(n));
      afoa_ptr_pair u_ptr (
        .i_mclk     (i_mclk),
        .i_reset_n  (i_reset_n),
        .i_step_inc (inc_src || inc_dst),
        .i_step_dec (dec_src || dec_dst),
        .i_wr_low   (wr_byte && (eff_dst[2:0] == KIND_LOW)),
        .i_wr_high  (wr_byte && (eff_dst[2:0] == KIND_HIGH)),
        .i_wdata    (alu_result),
        .o_ptr      (ptr[n])
      );
    end
  endgenerate
  assign ptr[3] = PTR_RESET;

  // Flags, accumulator and bank selector move on the execute edge
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags         <= FLAGS_RESET;
      o_acc         <= ACC_RESET;
      bank_selector <= BANK_RESET;
    end else begin
      flags <= next_flags;
      if (i_exec && to_acc) begin
        o_acc <= alu_result;
      end
      if (file_wr && dst_bank && keep_result) begin
        bank_selector <= alu_result[3:0];
      end
    end
  end

  assign o_flags = {3'b000, flags};

  // RAM write issued on the same edge the flags change
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wr_en   <= 1'b0;
      o_wr_addr <= 12'h000;
      o_wr_data <= 8'h00;
    end else begin
      o_wr_en <= file_wr && !dst_inner;
      if (file_wr && !dst_inner) begin
        o_wr_addr <= eff_dst;
        o_wr_data <= alu_result;
      end
    end
  end

  // Literal control transfer hands its full program address onward
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prog_load   <= 1'b0;
      o_prog_target <= 20'h00000;
    end else begin
      o_prog_load <= i_exec && op_goto;
      if (i_exec && op_goto) begin
        o_prog_target <= i_prog_addr;
      end
    end
  end
endmodule : afoa_core
`default_nettype wire

// *** tb/afoa_core_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module afoa_core_chk
  import afoa_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_reset_n,
  input wire logic        i_exec,
  input wire afoa_op_t    i_op,
  input wire logic [7:0]  i_file_addr,
  input wire logic        i_access_bit,
  input wire logic        i_dest_bit,
  input wire logic [7:0]  i_literal,
  input wire logic [19:0] i_prog_addr,
  input wire logic        o_rd_en,
  input wire logic [11:0] o_rd_addr,
  input wire logic        o_wr_en,
  input wire logic [7:0]  o_acc,
  input wire logic [7:0]  o_flags,
  input wire logic        o_prog_load,
  input wire logic [19:0] o_prog_target
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // Reference arithmetic, recomputed here rather than trusted from the ALU
  wire logic       add_go  = i_exec && (i_op == OP_ADD_LITERAL);
  wire logic       sub_go  = i_exec && (i_op == OP_LITERAL_MINUS_ACC);
  wire logic [8:0] add_sum = {1'h0, i_literal} + {1'h0, o_acc};
  wire logic [4:0] add_lo  = {1'h0, i_literal[3:0]} + {1'h0, o_acc[3:0]};
  wire logic [7:0] sub_dif = i_literal - o_acc;
  wire logic       sub_wrp = (i_literal[7] != o_acc[7]) && (sub_dif[7] != i_literal[7]);

  property p_top_zero;
    o_flags[7:5] == 3'h0;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("unimplemented flag bits not zero");
  property p_goto;
    i_exec && i_op == OP_GOTO_LITERAL |=> o_prog_load && o_prog_target == $past(i_prog_addr);
  endproperty
  a_goto: assert property (p_goto)
    else $error("jump target not loaded");
  property p_add_c;
    add_go |=> {o_flags[FLAG_C], o_acc} == $past(add_sum);
  endproperty
  a_add_c: assert property (p_add_c)
    else $error("add sum or carry wrong");
  property p_add_nib;
    add_go |=> o_flags[FLAG_NIB] == $past(add_lo[4]);
  endproperty
  a_add_nib: assert property (p_add_nib)
    else $error("add nibble carry wrong");
  property p_add_nz;
    add_go |=> o_flags[FLAG_N] == o_acc[7] && o_flags[FLAG_Z] == (o_acc == 8'h00);
  endproperty
  a_add_nz: assert property (p_add_nz)
    else $error("zero or negative flag wrong");
  property p_sub_c;
    sub_go |=> o_flags[FLAG_C] == $past(i_literal >= o_acc) && o_acc == $past(sub_dif);
  endproperty
  a_sub_c: assert property (p_sub_c)
    else $error("subtract borrow wrong");
  property p_sub_wrap;
    sub_go |=> o_flags[FLAG_WRAP] == $past(sub_wrp);
  endproperty
  a_sub_wrap: assert property (p_sub_wrap)
    else $error("subtract overflow wrong");
  property p_access;
    i_exec && i_op == OP_ADD_ACC_FILE && !i_access_bit && i_file_addr >= 8'h60
      && i_file_addr < 8'hd8 |-> o_rd_en && o_rd_addr == {{4{i_file_addr[7]}}, i_file_addr};
  endproperty
  a_access: assert property (p_access)
    else $error("forced access address wrong");
  property p_dest;
    i_exec && i_op == OP_ADD_ACC_FILE && !i_dest_bit |=> !o_wr_en;
  endproperty
  a_dest: assert property (p_dest)
    else $error("memory written with destination accumulator");
  property p_wr_cause;
    o_wr_en |-> $past(i_exec);
  endproperty
  a_wr_cause: assert property (p_wr_cause)
    else $error("write strobe without instruction");
endmodule : afoa_core_chk

bind afoa_core afoa_core_chk u_chk (
  .i_mclk, .i_reset_n, .i_exec, .i_op, .i_file_addr, .i_access_bit,
  .i_dest_bit, .i_literal, .i_prog_addr, .o_rd_en, .o_rd_addr, .o_wr_en,
  .o_acc, .o_flags, .o_prog_load, .o_prog_target
);
`default_nettype wire

// *** tb/afoa_ram_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module afoa_ram_model (
  input  wire logic        i_mclk,
  input  wire logic        i_rd_en,
  input  wire logic [11:0] i_rd_addr,
  input  wire logic        i_wr_en,
  input  wire logic [11:0] i_wr_addr,
  input  wire logic [7:0]  i_wr_data,
  output logic      [7:0]  o_rd_data
);
  logic [7:0] mem [4096];
  logic [7:0] junk;
  // Each byte holds its low address bits, so expected reads are obvious
  initial begin
    junk = 8'h5a;
    for (int i = 0; i < 4096; i++) mem[i] = i[7:0];
  end
  // Idle read port churns so the core cannot lean on a stale byte
  always @(posedge i_mclk) begin
    junk <= ~junk;
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end
  assign o_rd_data = i_rd_en ? mem[i_rd_addr] : junk;
endmodule : afoa_ram_model
`default_nettype wire

// *** tb/tb_alu_flags_and_operand_addressing.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_alu_flags_and_operand_addressing
  import afoa_pkg::*;
;
  typedef struct packed {
    afoa_op_t   op;
    logic [7:0] k;
    logic [4:0] m;
    logic [7:0] acc;
    logic [7:0] fl;
  } afoa_row_t;
  logic        i_mclk, i_reset_n, i_exec, i_access_bit, i_dest_bit;
  logic        i_extended_isa_enable, o_rd_en, o_wr_en, o_prog_load;
  afoa_op_t    i_op;
  logic [2:0]  i_bit_sel;
  logic [7:0]  i_file_addr, i_literal, i_rd_data, o_wr_data, o_acc, o_flags;
  logic [11:0] i_long_src, i_long_dst, o_rd_addr, o_wr_addr;
  logic [19:0] i_prog_addr, o_prog_target;
  logic        wr_en, pl;
  logic [11:0] rd_addr, wr_addr;
  logic [7:0]  wr_data, fl0;
  int          num_errors = 0;
  int          checks = 0;
  // Rows: op, literal or file address, {a, d, bit}, accumulator, flags
  afoa_row_t rows [18] = '{
    '{OP_MOVE_LITERAL, 8'h7f, 5'h00, 8'h7f, 8'h00},
    '{OP_ADD_LITERAL, 8'h01, 5'h00, 8'h80, 8'h1a},
    '{OP_ADD_LITERAL, 8'h81, 5'h00, 8'h01, 8'h09},
    '{OP_LITERAL_MINUS_ACC, 8'h00, 5'h00, 8'hff, 8'h10},
    '{OP_ADD_ACC_FILE, 8'h01, 5'h00, 8'h00, 8'h07},
    '{OP_FILE_MINUS_ACC, 8'h10, 5'h00, 8'h10, 8'h03},
    '{OP_AND_FILE, 8'h10, 5'h00, 8'h10, 8'h03},
    '{OP_ROTATE_LEFT, 8'h99, 5'h10, 8'h33, 8'h03},
    '{OP_ROTATE_RIGHT, 8'h99, 5'h10, 8'hcc, 8'h13},
    '{OP_ROTATE_LEFT, 8'h66, 5'h00, 8'hcd, 8'h10},
    '{OP_ROTATE_RIGHT, 8'h66, 5'h00, 8'h33, 8'h00},
    '{OP_MOVE_LITERAL, 8'h13, 5'h00, 8'h13, 8'h00},
    '{OP_ACC_TO_FILE, 8'hd8, 5'h00, 8'h13, 8'h13},
    '{OP_CLEAR_FILE, 8'hd8, 5'h00, 8'h13, 8'h17},
    '{OP_BIT_CLEAR, 8'hd8, 5'h04, 8'h13, 8'h07},
    '{OP_NIBBLE_SWAP, 8'hd8, 5'h08, 8'h13, 8'h10},
    '{OP_ADD_ACC_FILE, 8'hd8, 5'h08, 8'h13, 8'h00},
    '{OP_BIT_SET, 8'hd8, 5'h00, 8'h13, 8'h01}
  };

  afoa_core DUT (
    .i_mclk, .i_reset_n, .i_exec, .i_op, .i_file_addr, .i_access_bit,
    .i_dest_bit, .i_bit_sel, .i_literal, .i_long_src, .i_long_dst,
    .i_prog_addr, .i_extended_isa_enable, .i_rd_data, .o_rd_en, .o_rd_addr,
    .o_wr_en, .o_wr_addr, .o_wr_data, .o_acc, .o_flags, .o_prog_load,
    .o_prog_target
  );
  afoa_ram_model u_ram (
    .i_mclk, .i_rd_en(o_rd_en), .i_rd_addr(o_rd_addr), .i_wr_en(o_wr_en),
    .i_wr_addr(o_wr_addr), .i_wr_data(o_wr_data), .o_rd_data(i_rd_data)
  );

  initial begin
    i_mclk = 1'h0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic chk(string what, logic [19:0] seen, logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One instruction, then an idle edge so exec never repeats by accident
  task automatic run(afoa_op_t op, logic [7:0] k, logic [4:0] m);
    @(negedge i_mclk);
    i_exec = 1'h1;
    i_op = op;
    i_file_addr = k;
    i_literal = k;
    {i_access_bit, i_dest_bit, i_bit_sel} = m;
    #1 rd_addr = o_rd_addr;
    @(posedge i_mclk);
    #1 {wr_en, wr_addr, wr_data, pl} = {o_wr_en, o_wr_addr, o_wr_data, o_prog_load};
    @(negedge i_mclk) i_exec = 1'h0;
  endtask : run

  task automatic put(logic [7:0] f, logic [7:0] v);
    run(OP_MOVE_LITERAL, v, 5'h00);
    run(OP_ACC_TO_FILE, f, 5'h00);
  endtask : put

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Watchdog sized well above the roughly 100 cycles the tests need
  initial begin
    repeat (3000) @(posedge i_mclk);
    num_errors++;
    wrap_up();
  end

  initial begin
    {i_reset_n, i_exec, i_access_bit, i_dest_bit, i_extended_isa_enable} = 5'h00;
    i_op = OP_NOP;
    {i_bit_sel, i_file_addr, i_literal} = 19'h0;
    {i_long_src, i_long_dst, i_prog_addr} = 44'h0;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk) i_reset_n = 1'h1;
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].k, rows[i].m);
      chk("acc", o_acc, rows[i].acc);
      chk("flags", o_flags, rows[i].fl);
    end
    $display("table rows done");
    // Reset in mid-run must clear at once, without a clock edge
    @(negedge i_mclk) i_reset_n = 1'h0;
    #1 chk("rst flags", o_flags, 8'h00);
    chk("rst acc", o_acc, 8'h00);
    @(negedge i_mclk) i_reset_n = 1'h1;
    $display("reset test done");
    put(8'hd9, 8'h03);
    run(OP_ADD_ACC_FILE, 8'h10, 5'h10);
    chk("banked", rd_addr, 12'h310);
    run(OP_ADD_ACC_FILE, 8'h10, 5'h00);
    chk("access lo", rd_addr, 12'h010);
    run(OP_ADD_ACC_FILE, 8'h90, 5'h00);
    chk("access hi", rd_addr, 12'hf90);
    $display("bank test done");
    // Pointer 0 sits at 1ff so the first step rolls into the high byte
    put(8'he5, 8'hff);
    put(8'he6, 8'h01);
    fl0 = o_flags;
    run(OP_ACC_TO_FILE, 8'he1, 5'h00);
    chk("post_increment_operand", {wr_en, wr_addr}, 13'h11ff);
    chk("step flags", o_flags, fl0);
    run(OP_NIBBLE_SWAP, 8'he2, 5'h00);
    chk("post_decrement_operand", rd_addr, 12'h200);
    run(OP_NIBBLE_SWAP, 8'he3, 5'h00);
    chk("pre_increment_operand", rd_addr, 12'h200);
    run(OP_MOVE_LITERAL, 8'hff, 5'h00);
    run(OP_NIBBLE_SWAP, 8'he4, 5'h00);
    chk("offset", rd_addr, 12'h1ff);
    run(OP_NIBBLE_SWAP, 8'he0, 5'h00);
    chk("plain", rd_addr, 12'h200);
    // Pointer 1 aimed at another virtual operand: writes drop, reads give zero
    put(8'hed, 8'he0);
    put(8'hee, 8'h0f);
    run(OP_ACC_TO_FILE, 8'he8, 5'h00);
    chk("null write", wr_en, 1'h0);
    run(OP_NIBBLE_SWAP, 8'he8, 5'h00);
    chk("null read", o_acc, 8'h00);
    $display("pointer test done");
    put(8'hf5, 8'h40);
    i_extended_isa_enable = 1'h1;
    run(OP_NIBBLE_SWAP, 8'h05, 5'h00);
    chk("indexed", rd_addr, 12'h045);
    run(OP_NIBBLE_SWAP, 8'h60, 5'h00);
    chk("ext direct", rd_addr, 12'h060);
    i_extended_isa_enable = 1'h0;
    run(OP_NIBBLE_SWAP, 8'h05, 5'h00);
    chk("no index", rd_addr, 12'h005);
    $display("indexed test done");
    i_long_src = 12'h345;
    i_long_dst = 12'h567;
    run(OP_FILE_TO_FILE, 8'h00, 5'h10);
    chk("long src", rd_addr, 12'h345);
    chk("long dst", {wr_en, wr_addr}, 13'h1567);
    chk("long data", wr_data, 8'h45);
    run(OP_ADD_ACC_FILE, 8'h10, 5'h08);
    chk("to file", {wr_en, wr_addr}, 13'h1010);
    chk("file data", wr_data, 8'h60);
    chk("acc kept", o_acc, 8'h50);
    i_prog_addr = 20'habcde;
    run(OP_GOTO_LITERAL, 8'h00, 5'h00);
    chk("jump load", pl, 20'h1);
    chk("jump target", o_prog_target, 20'habcde);
    $display("move and jump test done");
    wrap_up();
  end
endmodule : tb_alu_flags_and_operand_addressing
`default_nettype wire
